// File: src/mmc_pkg.sv
// Behaviour
// R1: Host writes mode 01 to start single shot
// R2: Finished shot raises ready, publishes sample
// R3: Finished shot sets mode upper bit, idle
// R4: Host rewrite rate sets single-shot sample rate
// R5: Host shots at most 100 Hz / 150 Hz
// R6: Power bit picks high-res or low-power
// R7: First output after turn-on time, plus ODR
// R8: Filter or bias removal quarters bandwidth
// R9: Bias bit, plus single-shot bit in single
// R10: Bias removal pairs set and reset measurements
// R11: Continuous bias removal outputs pair average
// R12: Host averages set/reset pair in single
// R13: Set pulses continue without bias removal
// R14: Pulse-rate bit chooses set pulse frequency
// R15: Continuous mode measures every ODR period
`default_nettype none

package mmc_pkg;
  // Device register map and field layout
  localparam logic [7:0] ADDR_CFG_A = 8'h60;
  localparam logic [7:0] ADDR_CFG_B = 8'h61;
  localparam logic [7:0] ADDR_OUT_L = 8'h68;
  localparam logic [7:0] ADDR_OUT_H = 8'h69;
  localparam logic [7:0] CFG_A_RST  = 8'h03;
  localparam logic [7:0] CFG_B_RST  = 8'h00;
  localparam logic [7:0] MD_MASK    = 8'h03;
  localparam int MD_LSB   = 0;
  localparam int MD_MSB   = 1;
  localparam int ODR_LSB  = 2;
  localparam int ODR_MSB  = 3;
  localparam int LP_BIT   = 4;
  localparam int LPF_BIT  = 0;
  localparam int BIAS_BIT = 1;
  localparam int RATE_BIT = 2;
  localparam int SSB_BIT  = 4;
  localparam logic [1:0] MD_CONT   = 2'h0;
  localparam logic [1:0] MD_SINGLE = 2'h1;

  // Sample and timer widths
  localparam int SAMPLE_W = 16;
  localparam int TIMER_W  = 22;
  localparam logic [5:0] PULSE_SLOW_WRAP = 6'h00;

  // ODR period multipliers relative to the fastest rate
  localparam logic [3:0] MULT_10HZ = 4'ha;
  localparam logic [3:0] MULT_20HZ = 4'h5;
  localparam logic [3:0] MULT_50HZ = 4'h2;
  localparam logic [3:0] MULT_100HZ = 4'h1;

  // Timing
  localparam int  CLK_HZ     = 25_000_000;
  localparam real CLK_KHZ    = 25000.0;
  localparam real T_ON_HR_MS = 9.4;
  localparam real T_ON_LP_MS = 6.4;
  localparam int  T_ON_HR_CYC = $rtoi($ceil(T_ON_HR_MS * CLK_KHZ - 1.0e-6));
  localparam int  T_ON_LP_CYC = $rtoi($ceil(T_ON_LP_MS * CLK_KHZ - 1.0e-6));
  localparam int  ODR_MAX_HZ  = 100;
  localparam int  ODR_100_CYC = CLK_HZ / ODR_MAX_HZ;
  localparam int  SS_MAX_HR_HZ = 100;
  localparam int  SS_MAX_LP_HZ = 150;
  localparam int  GAP_HR_CYC = (CLK_HZ + SS_MAX_HR_HZ - 1) / SS_MAX_HR_HZ;
  localparam int  GAP_LP_CYC = (CLK_HZ + SS_MAX_LP_HZ - 1) / SS_MAX_LP_HZ;

  // Controller register map
  localparam logic [3:0] H_CFG_A = 4'h0;
  localparam logic [3:0] H_CFG_B = 4'h1;
  localparam logic [3:0] H_CMD   = 4'h2;
  localparam logic [3:0] H_RES_L = 4'h3;
  localparam logic [3:0] H_RES_H = 4'h4;
  localparam logic [3:0] H_STAT  = 4'h5;
  localparam logic [3:0] H_MASK  = 4'h6;
  localparam int CMD_GO_BIT = 0;
  localparam int STAT_W     = 2;
  localparam int STAT_DONE  = 0;
  localparam int STAT_REFUSED = 1;

  typedef enum logic [1:0] {
    DS_IDLE = 2'h0,
    DS_WARM = 2'h1,
    DS_RUN  = 2'h3
  } mmc_dev_state_type;

  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_GAP  = 3'h1,
    HS_TRIG = 3'h3,
    HS_WAIT = 3'h2,
    HS_RDL  = 3'h6,
    HS_RDH  = 3'h7,
    HS_CAP  = 3'h5
  } mmc_host_state_type;

  // Mean of two samples, arithmetic shift keeps the sign
  function automatic logic signed [SAMPLE_W-1:0] mmc_avg(
    input logic signed [SAMPLE_W-1:0] a,
    input logic signed [SAMPLE_W-1:0] b
  );
    logic signed [SAMPLE_W:0] s;
    s = (SAMPLE_W+1)'(a) + (SAMPLE_W+1)'(b);
    return s[SAMPLE_W:1];
  endfunction : mmc_avg

  function automatic logic [3:0] mmc_odr_mult(input logic [1:0] code);
    case (code)
      2'h0:    return MULT_10HZ;
      2'h1:    return MULT_20HZ;
      2'h2:    return MULT_50HZ;
      default: return MULT_100HZ;
    endcase
  endfunction : mmc_odr_mult
endpackage : mmc_pkg

`default_nettype wire

// File: src/mmc_link_if.sv
`default_nettype none

// Register link between controller and sensor; read data one cycle after rd
interface mmc_link_if;
  logic       wr;
  logic       rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       ready;

  modport dev (input wr, input rd, input addr, input wdata, output rdata, output ready);
  modport host (output wr, output rd, output addr, output wdata, input rdata, input ready);
endinterface : mmc_link_if

`default_nettype wire

// File: src/mmc_timer.sv
`default_nettype none

module mmc_timer #(
  parameter int W = 22
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              expire
);
  logic [W-1:0] remain;
  logic         run;

  // Expire pulses count cycles after load; a new load restarts the wait
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      remain <= '0;
      run    <= 1'b0;
      expire <= 1'b0;
    end
    else if (ce)
    begin
      expire <= 1'b0;
      if (load)
      begin
        remain <= count;
        run    <= 1'b1;
      end
      else if (run)
      begin
        remain <= remain - W'(1);
        if (remain <= W'(1))
        begin
          expire <= 1'b1;
          run    <= 1'b0;
        end
      end
    end
  end
endmodule : mmc_timer

`default_nettype wire

// File: src/mmc_device.sv
`default_nettype none

module mmc_device #(
  parameter int T_ON_HR_CYC = mmc_pkg::T_ON_HR_CYC,
  parameter int T_ON_LP_CYC = mmc_pkg::T_ON_LP_CYC,
  parameter int ODR_100_CYC = mmc_pkg::ODR_100_CYC
) (
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  input  wire logic                                ce,
  mmc_link_if.dev                                  link,
  input  wire logic signed [mmc_pkg::SAMPLE_W-1:0] sample_in,
  output logic                                     set_pulse,
  output logic                                     reset_pulse,
  output logic                                     bw_quarter
);
  localparam int TW = mmc_pkg::TIMER_W;
  localparam int SW = mmc_pkg::SAMPLE_W;

  mmc_pkg::mmc_dev_state_type state;
  mmc_pkg::mmc_dev_state_type next_state;
  logic [7:0]           cfg_a;
  logic [7:0]           cfg_b;
  logic signed [SW-1:0] out_data;
  logic signed [SW-1:0] other_sample;
  logic signed [SW-1:0] pair_value;
  logic signed [SW-1:0] next_out;
  logic [1:0]           md;
  logic                 low_power_select;
  logic                 smoothing_filter_enable;
  logic                 bias_removal_enable;
  logic                 polarize_pulse_rate;
  logic                 single_shot_bias_removal;
  logic                 single;
  logic                 cont;
  logic                 alternate;
  logic                 pair_avg;
  logic                 polarity;
  logic [5:0]           pulse_cnt;
  logic                 fire;
  logic                 publish;
  logic                 go_idle_hw;
  logic                 expire;
  logic [TW-1:0]        t_on;
  logic [TW-1:0]        odr_cyc;
  logic [TW-1:0]        load_cnt;

  // Field decode of the two configuration bytes
  assign md                       = cfg_a[mmc_pkg::MD_MSB:mmc_pkg::MD_LSB];
  assign low_power_select         = cfg_a[mmc_pkg::LP_BIT];
  assign smoothing_filter_enable  = cfg_b[mmc_pkg::LPF_BIT];
  assign bias_removal_enable      = cfg_b[mmc_pkg::BIAS_BIT];
  assign polarize_pulse_rate      = cfg_b[mmc_pkg::RATE_BIT];
  assign single_shot_bias_removal = cfg_b[mmc_pkg::SSB_BIT];
  assign single = (md == mmc_pkg::MD_SINGLE);
  assign cont   = (md == mmc_pkg::MD_CONT);

  // Single shot alternates polarity only with both bias bits set
  assign alternate = bias_removal_enable & (cont | (single & single_shot_bias_removal)); // see R9 see R10
  assign pair_avg  = cont & bias_removal_enable; // see R11

  // Power mode picks the warm-up time; ODR code scales the base period
  assign t_on = low_power_select ? TW'(T_ON_LP_CYC) : TW'(T_ON_HR_CYC); // see R6 see R7
  assign odr_cyc = TW'(ODR_100_CYC * int'(mmc_pkg::mmc_odr_mult(cfg_a[mmc_pkg::ODR_MSB:mmc_pkg::ODR_LSB])));

  // Output value: pair average, then optional smoothing against last output
  assign pair_value = pair_avg ? mmc_pkg::mmc_avg(sample_in, other_sample) : sample_in; // see R11
  assign next_out = smoothing_filter_enable ? mmc_pkg::mmc_avg(pair_value, out_data) : pair_value; // see R8

  mmc_timer #(
    .W (TW)
  ) meas_timer (
    .clk    (clk),
    .rst_n  (rst_n),
    .ce     (ce),
    .load   (fire),
    .count  (load_cnt),
    .expire (expire)
  );

  // Sequencing: warm-up from idle, then one shot in single mode or one measurement per ODR period in continuous
  always_comb
  begin
    next_state = state;
    fire       = 1'b0;
    publish    = 1'b0;
    go_idle_hw = 1'b0;
    load_cnt   = odr_cyc;
    case (state)
      mmc_pkg::DS_IDLE:
      begin
        if (!md[1]) // see R1
        begin
          fire       = 1'b1;
          load_cnt   = t_on; // see R7
          next_state = mmc_pkg::DS_WARM;
        end
      end
      mmc_pkg::DS_WARM, mmc_pkg::DS_RUN:
      begin
        if (md[1])
          next_state = mmc_pkg::DS_IDLE;
        else if (expire && single)
        begin
          publish    = 1'b1; // see R2
          go_idle_hw = 1'b1; // see R3
          next_state = mmc_pkg::DS_IDLE;
        end
        else if (expire)
        begin
          // First paired sample only primes the pair: turn-on plus one ODR
          publish    = !(pair_avg && state == mmc_pkg::DS_WARM); // see R7 see R15
          fire       = 1'b1; // see R15
          // Reload one short: the step from expire to reload costs a cycle
          load_cnt   = odr_cyc - TW'(1); // see R15
          next_state = mmc_pkg::DS_RUN;
        end
      end
      default:
        next_state = mmc_pkg::DS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= mmc_pkg::DS_IDLE;
    else if (ce)
      state <= next_state;
  end

  // Configuration writes; the automatic return to idle wins a same-cycle write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_a <= mmc_pkg::CFG_A_RST;
      cfg_b <= mmc_pkg::CFG_B_RST;
    end
    else if (ce)
    begin
      if (link.wr && link.addr == mmc_pkg::ADDR_CFG_A)
        cfg_a <= link.wdata;
      if (link.wr && link.addr == mmc_pkg::ADDR_CFG_B)
        cfg_b <= link.wdata;
      if (go_idle_hw)
        cfg_a[mmc_pkg::MD_MSB] <= 1'b1; // see R3
    end
  end

  // Polarizing pulses: alternate set/reset when pairing, else set at chosen rate
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      set_pulse   <= 1'b0;
      reset_pulse <= 1'b0;
      polarity    <= 1'b0;
      pulse_cnt   <= '0;
    end
    else if (ce)
    begin
      set_pulse   <= 1'b0;
      reset_pulse <= 1'b0;
      if (fire && alternate)
      begin
        set_pulse   <= !polarity; // see R10
        reset_pulse <= polarity; // see R10
        polarity    <= !polarity;
      end
      else if (fire)
      begin
        // Sparse pulses save power but let offset drift between them
        set_pulse <= polarize_pulse_rate || pulse_cnt == mmc_pkg::PULSE_SLOW_WRAP; // see R13 see R14
        pulse_cnt <= pulse_cnt + 6'h01;
        polarity  <= 1'b0;
      end
    end
  end

  // Sample capture and output registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_data     <= '0;
      other_sample <= '0;
    end
    else if (ce)
    begin
      if (expire && state != mmc_pkg::DS_IDLE)
        other_sample <= sample_in; // see R10
      if (publish)
        out_data <= next_out; // see R2
    end
  end

  // Ready pin: set on a new result, cleared by reading the high byte
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      link.ready <= 1'b0;
    else if (ce)
    begin
      if (publish)
        link.ready <= 1'b1; // see R2
      else if (link.rd && link.addr == mmc_pkg::ADDR_OUT_H)
        link.ready <= 1'b0;
    end
  end

  // Read port, data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      link.rdata <= 8'h00;
    else if (ce)
    begin
      link.rdata <= 8'h00;
      if (link.rd)
      begin
        case (link.addr)
          mmc_pkg::ADDR_CFG_A: link.rdata <= cfg_a;
          mmc_pkg::ADDR_CFG_B: link.rdata <= cfg_b;
          mmc_pkg::ADDR_OUT_L: link.rdata <= out_data[7:0];
          mmc_pkg::ADDR_OUT_H: link.rdata <= out_data[SW-1:8];
          default:             link.rdata <= 8'h00;
        endcase
      end
    end
  end

  // Bandwidth indicator follows filter and bias settings
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bw_quarter <= 1'b0;
    else if (ce)
      bw_quarter <= smoothing_filter_enable | bias_removal_enable; // see R8
  end
endmodule : mmc_device

`default_nettype wire

// File: src/mmc_host.sv
`default_nettype none

module mmc_host #(
  parameter int GAP_HR_CYC = mmc_pkg::GAP_HR_CYC,
  parameter int GAP_LP_CYC = mmc_pkg::GAP_LP_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  mmc_link_if.host        link,
  input  wire logic [3:0] sw_addr,
  input  wire logic [7:0] sw_wdata,
  input  wire logic       sw_wr,
  input  wire logic       sw_rd,
  output logic [7:0]      sw_rdata,
  output logic            irq
);
  localparam int TW = mmc_pkg::TIMER_W;
  localparam int SW = mmc_pkg::SAMPLE_W;
  localparam int NW = mmc_pkg::STAT_W;

  mmc_pkg::mmc_host_state_type state;
  logic [7:0]           img_a;
  logic [7:0]           img_b;
  logic [7:0]           lo_byte;
  logic [7:0]           shot_cfg;
  logic signed [SW-1:0] first;
  logic signed [SW-1:0] result;
  logic signed [SW-1:0] sample;
  logic                 pairing;
  logic                 second;
  logic                 gap_busy;
  logic                 gap_done;
  logic [NW-1:0]        stat;
  logic [NW-1:0]        mask;
  logic [NW-1:0]        evt;
  logic                 cfg_wr;
  logic                 go_cmd;
  logic                 idle;
  logic                 done_evt;

  assign idle     = (state == mmc_pkg::HS_IDLE);
  assign cfg_wr   = sw_wr && (sw_addr == mmc_pkg::H_CFG_A || sw_addr == mmc_pkg::H_CFG_B);
  assign go_cmd   = sw_wr && sw_addr == mmc_pkg::H_CMD && sw_wdata[mmc_pkg::CMD_GO_BIT];
  assign sample   = {link.rdata, lo_byte};
  assign done_evt = (state == mmc_pkg::HS_CAP) && !(pairing && !second);
  assign evt[mmc_pkg::STAT_DONE]    = done_evt;
  assign evt[mmc_pkg::STAT_REFUSED] = (cfg_wr || go_cmd) && !idle;
  // Trigger byte is the stored image with the mode forced to single shot
  assign shot_cfg = (img_a & ~mmc_pkg::MD_MASK) | 8'(mmc_pkg::MD_SINGLE); // see R1

  // Least spacing between triggers depends on the power mode
  mmc_timer #(
    .W (TW)
  ) gap_timer (
    .clk    (clk),
    .rst_n  (rst_n),
    .ce     (ce),
    .load   (state == mmc_pkg::HS_TRIG),
    .count  (img_a[mmc_pkg::LP_BIT] ? TW'(GAP_LP_CYC) : TW'(GAP_HR_CYC)), // see R5
    .expire (gap_done)
  );

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      gap_busy <= 1'b0;
    else if (ce)
    begin
      if (state == mmc_pkg::HS_TRIG)
        gap_busy <= 1'b1;
      else if (gap_done)
        gap_busy <= 1'b0;
    end
  end

  // Configuration images, accepted only while idle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      img_a <= mmc_pkg::CFG_A_RST;
      img_b <= mmc_pkg::CFG_B_RST;
    end
    else if (ce && idle && sw_wr)
    begin
      if (sw_addr == mmc_pkg::H_CFG_A)
        img_a <= sw_wdata;
      if (sw_addr == mmc_pkg::H_CFG_B)
        img_b <= sw_wdata; // see R9
    end
  end

  // Link sequencer: forward writes, trigger shots, fetch and combine results
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state      <= mmc_pkg::HS_IDLE;
      link.wr    <= 1'b0;
      link.rd    <= 1'b0;
      link.addr  <= 8'h00;
      link.wdata <= 8'h00;
      pairing    <= 1'b0;
      second     <= 1'b0;
      lo_byte    <= 8'h00;
      first      <= '0;
      result     <= '0;
    end
    else if (ce)
    begin
      link.wr <= 1'b0;
      case (state)
        mmc_pkg::HS_IDLE:
        begin
          if (cfg_wr)
          begin
            link.wr    <= 1'b1;
            link.addr  <= (sw_addr == mmc_pkg::H_CFG_A) ? mmc_pkg::ADDR_CFG_A : mmc_pkg::ADDR_CFG_B;
            link.wdata <= sw_wdata;
          end
          else if (go_cmd)
          begin
            // In single shot the device alternates polarity only with both bias bits set
            pairing <= img_b[mmc_pkg::BIAS_BIT] & img_b[mmc_pkg::SSB_BIT]; // see R12
            second  <= 1'b0;
            state   <= mmc_pkg::HS_GAP;
          end
          else if (link.ready)
          begin
            pairing   <= 1'b0;
            link.rd   <= 1'b1;
            link.addr <= mmc_pkg::ADDR_OUT_L;
            state     <= mmc_pkg::HS_RDL;
          end
        end
        mmc_pkg::HS_GAP:
          if (!gap_busy) // see R5
            state <= mmc_pkg::HS_TRIG;
        mmc_pkg::HS_TRIG:
        begin
          link.wr    <= 1'b1; // see R1 see R4
          link.addr  <= mmc_pkg::ADDR_CFG_A;
          link.wdata <= shot_cfg;
          state      <= mmc_pkg::HS_WAIT;
        end
        mmc_pkg::HS_WAIT:
          if (link.ready)
          begin
            link.rd   <= 1'b1;
            link.addr <= mmc_pkg::ADDR_OUT_L;
            state     <= mmc_pkg::HS_RDL;
          end
        mmc_pkg::HS_RDL:
        begin
          link.addr <= mmc_pkg::ADDR_OUT_H;
          state     <= mmc_pkg::HS_RDH;
        end
        mmc_pkg::HS_RDH:
        begin
          link.rd <= 1'b0;
          lo_byte <= link.rdata;
          state   <= mmc_pkg::HS_CAP;
        end
        mmc_pkg::HS_CAP:
        begin
          if (pairing && !second)
          begin
            first  <= sample;
            second <= 1'b1;
            state  <= mmc_pkg::HS_GAP;
          end
          else
          begin
            result <= pairing ? mmc_pkg::mmc_avg(first, sample) : sample; // see R12
            state  <= mmc_pkg::HS_IDLE;
          end
        end
        default:
          state <= mmc_pkg::HS_IDLE;
      endcase
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat <= '0;
      mask <= '0;
      irq  <= 1'b0;
    end
    else if (ce)
    begin
      if (sw_wr && sw_addr == mmc_pkg::H_STAT)
        stat <= (stat & ~sw_wdata[NW-1:0]) | evt;
      else
        stat <= stat | evt;
      if (sw_wr && sw_addr == mmc_pkg::H_MASK)
        mask <= sw_wdata[NW-1:0];
      irq <= |(stat & mask); // One cycle behind the status bits
    end
  end

  // Software read port, data in the cycle after the strobe only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sw_rdata <= 8'h00;
    else if (ce)
    begin
      sw_rdata <= 8'h00;
      if (sw_rd)
      begin
        case (sw_addr)
          mmc_pkg::H_CFG_A: sw_rdata <= img_a;
          mmc_pkg::H_CFG_B: sw_rdata <= img_b;
          mmc_pkg::H_RES_L: sw_rdata <= result[7:0];
          mmc_pkg::H_RES_H: sw_rdata <= result[SW-1:8];
          mmc_pkg::H_STAT:  sw_rdata <= {5'h00, !idle, stat};
          mmc_pkg::H_MASK:  sw_rdata <= {6'h00, mask};
          default:          sw_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule : mmc_host

`default_nettype wire

// File: dv/mmc_asserts.sv
`default_nettype none

module mmc_asserts (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       ready,
  input wire logic       set_pulse,
  input wire logic       reset_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Single shot written on the link
  sequence s_shot;
    wr && addr == mmc_pkg::ADDR_CFG_A && wdata[1:0] == mmc_pkg::MD_SINGLE;
  endsequence
  // Low byte then high byte, then the read strobe drops
  sequence s_fetch;
    rd && addr == mmc_pkg::ADDR_OUT_L ##1 rd && addr == mmc_pkg::ADDR_OUT_H ##1 !rd;
  endsequence

  chk_shot_ready: assert property (s_shot |-> ##[1:200] $rose(ready))
    else $error("single shot gave no result");
  chk_shot_pulse: assert property (s_shot |-> ##[1:8] (set_pulse || reset_pulse))
    else $error("no polarize pulse at shot start");
  chk_ready_fetch: assert property ($rose(ready) |=> s_fetch)
    else $error("result not fetched low then high");
  chk_ready_hold: assert property (ready && !(rd && addr == mmc_pkg::ADDR_OUT_H) |=> ready)
    else $error("ready dropped before the result was read");
  chk_pulse_excl: assert property (!(set_pulse && reset_pulse))
    else $error("set and reset pulse together");
  chk_pulse_short: assert property (set_pulse |=> !set_pulse)
    else $error("set pulse longer than one cycle");
  chk_rdata_zero: assert property (!rd |=> rdata == 8'h00)
    else $error("read data without a read");
  chk_fetch_order: assert property (rd && addr == mmc_pkg::ADDR_OUT_H |-> $past(addr) == mmc_pkg::ADDR_OUT_L)
    else $error("high byte read without low byte");
endmodule : mmc_asserts

`default_nettype wire

// File: dv/magnetometer_measure_control_test.sv
`default_nettype none

module magnetometer_measure_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int               T_HR  = 40;
  localparam int               T_LP  = 30;
  localparam int               ODR   = 20;
  localparam int               GAP   = 60;
  localparam logic signed [15:0] FIELD = 16'sh0100;
  localparam logic signed [15:0] BIAS  = 16'sh0040;
  logic               clk       = 1'b0;
  logic               rst_n     = 1'b0;
  logic [3:0]         sw_addr   = 4'h0;
  logic [7:0]         sw_wdata  = 8'h00;
  logic               sw_wr     = 1'b0;
  logic               sw_rd     = 1'b0;
  logic signed [15:0] sample_in = 16'sh0140;
  logic               rdy_d     = 1'b0;
  logic [7:0]         sw_rdata;
  logic               irq;
  logic               set_pulse;
  logic               reset_pulse;
  logic               bw_quarter;
  int                 cyc, t_wr, t_gap, t_rdy, t_prev, n_rdy, n_set, fails, cmp_count, lat_hr, n0;

  mmc_link_if lk ();
  mmc_device #(.T_ON_HR_CYC(T_HR), .T_ON_LP_CYC(T_LP), .ODR_100_CYC(ODR)) i_mmc_device (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .link(lk.dev), .sample_in(sample_in),
    .set_pulse(set_pulse), .reset_pulse(reset_pulse), .bw_quarter(bw_quarter));
  mmc_host #(.GAP_HR_CYC(GAP), .GAP_LP_CYC(40)) i_mmc_host (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .link(lk.host), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq));
  mmc_asserts i_mmc_asserts (
    .clk(clk), .rst_n(rst_n), .wr(lk.wr), .rd(lk.rd), .addr(lk.addr), .wdata(lk.wdata),
    .rdata(lk.rdata), .ready(lk.ready), .set_pulse(set_pulse), .reset_pulse(reset_pulse));

  always #20 clk = ~clk;

  // Front end reads field plus offset after set, minus after reset, so a pair averages out
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    rdy_d <= lk.ready;
    if (set_pulse) n_set <= n_set + 1;
    if (set_pulse) sample_in <= FIELD + BIAS;
    if (reset_pulse) sample_in <= FIELD - BIAS;
    if (lk.wr && lk.addr == mmc_pkg::ADDR_CFG_A) t_gap <= cyc - t_wr;
    if (lk.wr && lk.addr == mmc_pkg::ADDR_CFG_A) t_wr <= cyc;
    if (lk.ready && !rdy_d)
    begin
      t_prev <= t_rdy;
      t_rdy <= cyc;
      n_rdy <= n_rdy + 1;
    end
  end

  task automatic end_of_test();
    $display("Compares %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task automatic check(input logic ok, input string what);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask : check

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask : reg_wr

  // Data stands only in the cycle after the strobe, so sample just past that edge
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1;
    check(sw_rdata === exp, what);
  endtask : reg_rd

  task automatic wait_irq();
    int n = 0;
    while (irq !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    if (irq !== 1'b1)
    begin
      check(1'b0, "no interrupt");
      end_of_test();
    end
  endtask : wait_irq

  task automatic shot(input logic [15:0] exp);
    reg_wr(4'h2, 8'h01);
    wait_irq();
    reg_rd(4'h3, exp[7:0], "result low");
    reg_rd(4'h4, exp[15:8], "result high");
    reg_wr(4'h5, 8'h01);
  endtask : shot

  task automatic t_init();
    reg_wr(4'h6, 8'h01);
    reg_rd(4'hf, 8'h00, "unmapped read");
    reg_rd(4'h5, 8'h00, "status after reset");
    reg_wr(4'h1, 8'h05);
    repeat (4) @(posedge clk);
    check(bw_quarter === 1'b1, "filter bandwidth");
    reg_wr(4'h1, 8'h04);
    repeat (4) @(posedge clk);
    check(bw_quarter === 1'b0, "plain bandwidth");
    $display("init done");
  endtask : t_init

  // Shot returns to idle: exactly one result, no further measurement
  task automatic t_single();
    reg_wr(4'h0, 8'h03);
    n0 = n_rdy + 1;
    shot(FIELD + BIAS);
    lat_hr = t_rdy - t_wr;
    repeat (100) @(posedge clk);
    check(n_rdy == n0, "device left idle");
    check(n_set > 0, "no set pulse");
    $display("single done");
  endtask : t_single

  task automatic t_lowpower();
    reg_wr(4'h0, 8'h13);
    shot(FIELD + BIAS);
    check(t_rdy - t_wr == lat_hr - (T_HR - T_LP), "low power turn-on");
    $display("low power done");
  endtask : t_lowpower

  // Two shots after set and reset; host average cancels the offset
  task automatic t_bias_single();
    reg_wr(4'h1, 8'h16);
    reg_wr(4'h0, 8'h03);
    n0 = n_rdy + 2;
    shot(FIELD);
    check(n_rdy == n0, "shot pair count");
    check(t_gap >= GAP, "shot spacing");
    $display("bias single done");
  endtask : t_bias_single

  task automatic t_refuse();
    reg_wr(4'h1, 8'h04);
    reg_wr(4'h2, 8'h01);
    reg_wr(4'h0, 8'h13);
    wait_irq();
    reg_rd(4'h5, 8'h03, "refused flag");
    reg_wr(4'h5, 8'h03);
    reg_rd(4'h5, 8'h00, "status cleared");
    $display("refuse done");
  endtask : t_refuse

  task automatic t_mask();
    reg_wr(4'h6, 8'h00);
    reg_wr(4'h2, 8'h01);
    repeat (200) @(posedge clk);
    check(irq === 1'b0, "masked interrupt");
    reg_rd(4'h5, 8'h01, "done while masked");
    reg_wr(4'h6, 8'h01);
    repeat (3) @(posedge clk);
    check(irq === 1'b1, "unmasked interrupt");
    reg_wr(4'h5, 8'h01);
    repeat (3) @(posedge clk);
    check(irq === 1'b0, "cleared interrupt");
    $display("mask done");
  endtask : t_mask

  // Continuous with bias removal: averaged output, extra period at start, one per period
  task automatic t_cont();
    int first;
    reg_wr(4'h1, 8'h06);
    reg_wr(4'h0, 8'h0c);
    wait_irq();
    first = t_rdy - t_wr;
    reg_rd(4'h3, FIELD[7:0], "average low");
    reg_rd(4'h4, FIELD[15:8], "average high");
    check(first == lat_hr + ODR, "bias turn-on");
    n0 = n_rdy + 1;
    repeat (ODR + 2) @(posedge clk);
    check(n_rdy == n0 && t_rdy - t_prev == ODR, "output period");
    reg_wr(4'h0, 8'h03);
    $display("continuous done");
  endtask : t_cont

  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_init();
    t_single();
    t_lowpower();
    t_bias_single();
    t_refuse();
    t_mask();
    t_cont();
    end_of_test();
  end
endmodule : magnetometer_measure_control_test

`default_nettype wire
